// ==== rtl/ecws_event_capture.sv ====
`default_nettype none
module ecws_event_capture
   import ecws_pkg::*;
#(
   parameter int EVENT_DELAY_CYCLES = ECWS_EVENT_DELAY_CYCLES
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic power_on_evt,
   input wire logic overtemp_evt,
   input wire logic spi_bitcount_err,
   input wire logic illegal_code_err,
   input wire logic locked_write_err,
   input wire logic wd_overflow,
   input wire logic wd_early_trigger,
   input wire logic wd_mode_window,
   input wire logic wd_mode_timeout,
   input wire logic sensor_over_evt,
   input wire logic sensor_under_evt,
   input wire logic mcu_supply_low_evt,
   input wire logic reset_threshold_sel,
   input wire logic bus_silence_evt,
   input wire logic can_uv_deact_evt,
   input wire logic txd_clamp_evt,
   input wire logic bus_wake_evt,
   input wire logic wake_pin,
   input wire logic overtemp_en,
   input wire logic serial_fault_en,
   input wire logic sensor_over_en,
   input wire logic sensor_under_en,
   input wire logic mcu_supply_low_en,
   input wire logic bus_silence_enable,
   input wire logic can_failure_en,
   input wire logic bus_wake_en,
   input wire logic wake_rise_en,
   input wire logic wake_fall_en,
   input wire logic in_sleep,
   input wire logic trx_offline,
   input wire logic mcu_supply_on,
   input wire logic system_reset_out,
   input wire logic mode_write,
   input wire logic [2:0] sbc_mode_field,
   input wire logic sleep_lock_bit,
   input wire logic clear_strobe,
   input wire ecws_flags_type clear_mask,
   output ecws_flags_type status_flags,
   output logic [3:0] global_status,
   output logic rxd_low,
   output logic sys_reset_req,
   output logic to_reset_req,
   output logic sleep_grant,
   output logic wake_request,
   output logic delay_running
);
   localparam logic [ECWS_TIMER_WIDTH-1:0] DELAY_LOAD = EVENT_DELAY_CYCLES[ECWS_TIMER_WIDTH-1:0];

   ecws_state_type state_reg;
   ecws_state_type state_next;
   ecws_flags_type set_vec;
   ecws_flags_type clr_vec;
   logic wd_fail;
   logic sleep_cmd;
   logic any_pending;
   logic any_cleared;
   logic reset_fell;
   logic wake_enabled;

   function automatic logic [3:0] ecws_global(input ecws_flags_type f);
      logic [3:0] g;
      g = 4'h0;
      g[ECWS_GLOBAL_SYSTEM] = f.battery_restored_flag | f.overtemp_warning_flag
         | f.serial_fault_flag | f.watchdog_fault_flag;
      g[ECWS_GLOBAL_SUPPLY] = f.sensor_supply_over_flag | f.sensor_supply_under_flag
         | f.mcu_supply_low_flag;
      g[ECWS_GLOBAL_TRX] = f.bus_silence_flag | f.can_failure_flag | f.bus_wake_flag;
      g[ECWS_GLOBAL_WAKE] = f.wake_rise_flag | f.wake_fall_flag;
      return g;
   endfunction : ecws_global

   always_comb begin
      wd_fail = (wd_overflow & (wd_mode_window | wd_mode_timeout))
         | (wd_early_trigger & wd_mode_window);
      sleep_cmd = mode_write & (sbc_mode_field == ECWS_MODE_SLEEP);
      wake_enabled = bus_wake_en | wake_rise_en | wake_fall_en;
      any_pending = |state_reg.flags;
      reset_fell = state_reg.reset_out_prev & ~system_reset_out;

      set_vec = '0;
      set_vec.battery_restored_flag = power_on_evt;
      set_vec.watchdog_fault_flag = wd_fail;
      set_vec.overtemp_warning_flag = overtemp_en & overtemp_evt & ~in_sleep;
      set_vec.serial_fault_flag = serial_fault_en & ((~in_sleep & (spi_bitcount_err
         | illegal_code_err | locked_write_err)) | (sleep_cmd & sleep_lock_bit));
      set_vec.sensor_supply_over_flag = ECWS_HAS_SENSOR_SUPPLY & sensor_over_en
         & sensor_over_evt;
      set_vec.sensor_supply_under_flag = ECWS_HAS_SENSOR_SUPPLY & sensor_under_en
         & sensor_under_evt;
      // Threshold select deliberately unused
      set_vec.mcu_supply_low_flag = mcu_supply_low_en & mcu_supply_low_evt & ~in_sleep;
      set_vec.bus_silence_flag = bus_silence_enable & bus_silence_evt;
      set_vec.can_failure_flag = can_failure_en & (can_uv_deact_evt
         | (txd_clamp_evt & ~in_sleep));
      set_vec.bus_wake_flag = bus_wake_en & bus_wake_evt;
      set_vec.wake_rise_flag = wake_rise_en & ~state_reg.wake_pin_prev & wake_pin;
      set_vec.wake_fall_flag = wake_fall_en & state_reg.wake_pin_prev & ~wake_pin;

      clr_vec = clear_strobe ? clear_mask : '0;
      any_cleared = |(clr_vec & state_reg.flags);

      state_next = state_reg;
      state_next.flags = (state_reg.flags & ~clr_vec) | set_vec;
      state_next.global_status = ecws_global(state_next.flags);
      state_next.reset_out_prev = system_reset_out;
      state_next.wake_pin_prev = wake_pin;

      // Delay timer: reset-output fall beats a new start
      if (reset_fell) begin
         state_next.delay_running = 1'b0;
         state_next.delay_count = '0;
      end else if (any_cleared) begin
         state_next.delay_running = 1'b1;
         state_next.delay_count = DELAY_LOAD;
      end else if (state_reg.delay_running) begin
         state_next.delay_count = state_reg.delay_count - 1'b1;
         if (state_reg.delay_count <= 16'h0001) begin
            state_next.delay_running = 1'b0;
         end
      end

      state_next.rxd_low = ~state_next.delay_running & (|state_next.flags)
         & ((trx_offline & mcu_supply_on) | in_sleep);

      state_next.wake_request = in_sleep & (|set_vec);

      state_next.sys_reset_req = (wd_fail & wd_mode_window)
         | (wd_overflow & wd_mode_timeout & state_reg.flags.watchdog_fault_flag);
      state_next.to_reset_req = 1'b0;
      state_next.sleep_grant = 1'b0;
      if (sleep_cmd & ~sleep_lock_bit) begin
         if (!wake_enabled) begin
            state_next.sys_reset_req = 1'b1;
         end else if (any_pending) begin
            state_next.to_reset_req = 1'b1;
         end else begin
            state_next.sleep_grant = 1'b1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign status_flags = state_reg.flags;
   assign global_status = state_reg.global_status;
   assign rxd_low = state_reg.rxd_low;
   assign sys_reset_req = state_reg.sys_reset_req;
   assign to_reset_req = state_reg.to_reset_req;
   assign sleep_grant = state_reg.sleep_grant;
   assign wake_request = state_reg.wake_request;
   assign delay_running = state_reg.delay_running;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);

   a_power_on_capture: assert property (
      power_on_evt |=> status_flags.battery_restored_flag)
      else $error("power-on event not captured");

   a_otw_sleep_block: assert property (
      (in_sleep && !status_flags.overtemp_warning_flag) |=> !status_flags.overtemp_warning_flag)
      else $error("overtemperature flag set in sleep");

   a_wd_window_reset: assert property (
      (wd_early_trigger && wd_mode_window) |=> (sys_reset_req && status_flags.watchdog_fault_flag))
      else $error("window failure without reset");

   a_wd_timeout_first: assert property (
      (wd_overflow && wd_mode_timeout && !wd_mode_window && !status_flags.watchdog_fault_flag
       && !mode_write) |=> (!sys_reset_req && status_flags.watchdog_fault_flag))
      else $error("first timeout overflow caused reset");

   a_set_beats_clear: assert property (
      (bus_wake_evt && bus_wake_en && clear_strobe && clear_mask.bus_wake_flag)
      |=> status_flags.bus_wake_flag)
      else $error("event lost in clear cycle");

   a_clear_start_timer: assert property (
      (clear_strobe && |(clear_mask & status_flags) && system_reset_out)
      |=> (delay_running && !rxd_low))
      else $error("clear did not start delay");

   a_timer_stop_rst: assert property (
      $fell(system_reset_out) |=> !delay_running)
      else $error("timer kept running after reset fall");

   a_rxd_after_delay: assert property (
      (delay_running && !$past(delay_running)) |-> !rxd_low [*2])
      else $error("receive pin low during delay");

   a_sleep_pending: assert property (
      (sleep_cmd && !sleep_lock_bit && wake_enabled && any_pending)
      |=> (to_reset_req && !sleep_grant))
      else $error("sleep entered with pending event");

   a_sleep_locked: assert property (
      (sleep_cmd && sleep_lock_bit) |=> (!sleep_grant && !to_reset_req))
      else $error("locked sleep command acted");

   a_no_wake_reset: assert property (
      (sleep_cmd && !sleep_lock_bit && !wake_enabled) |=> (sys_reset_req && !sleep_grant))
      else $error("sleep without wake source");
endmodule : ecws_event_capture
`default_nettype wire

// ==== rtl/ecws_pkg.sv ====
`default_nettype none
package ecws_pkg;
   localparam int ECWS_CLK_PERIOD_NS = 20;
   localparam int ECWS_EVENT_DELAY_US = 100;
   localparam int ECWS_EVENT_DELAY_CYCLES = ECWS_EVENT_DELAY_US * 1000 / ECWS_CLK_PERIOD_NS;
   localparam int ECWS_TIMER_WIDTH = 16;
   localparam logic [2:0] ECWS_MODE_SLEEP = 3'h1;
   localparam logic ECWS_HAS_SENSOR_SUPPLY = 1'h1;
   localparam int ECWS_GLOBAL_SYSTEM = 0;
   localparam int ECWS_GLOBAL_SUPPLY = 1;
   localparam int ECWS_GLOBAL_TRX = 2;
   localparam int ECWS_GLOBAL_WAKE = 3;

   typedef struct packed {
      logic battery_restored_flag;
      logic overtemp_warning_flag;
      logic serial_fault_flag;
      logic watchdog_fault_flag;
      logic sensor_supply_over_flag;
      logic sensor_supply_under_flag;
      logic mcu_supply_low_flag;
      logic bus_silence_flag;
      logic can_failure_flag;
      logic bus_wake_flag;
      logic wake_rise_flag;
      logic wake_fall_flag;
   } ecws_flags_type;

   typedef struct packed {
      ecws_flags_type flags;
      logic [3:0] global_status;
      logic [ECWS_TIMER_WIDTH-1:0] delay_count;
      logic delay_running;
      logic rxd_low;
      logic reset_out_prev;
      logic wake_pin_prev;
      logic sys_reset_req;
      logic to_reset_req;
      logic sleep_grant;
      logic wake_request;
   } ecws_state_type;
endpackage : ecws_pkg
`default_nettype wire

// ==== verification/ecws_host_model.sv ====
`default_nettype none
module ecws_host_model
   import ecws_pkg::*;
(
   input wire logic clock,
   input wire logic clear_req,
   input wire ecws_flags_type status_flags,
   output logic clear_strobe,
   output ecws_flags_type clear_mask
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      clear_strobe = 1'h0;
      clear_mask = '0;
   end
   // Clears only the bits it has just read
   always @(posedge clock) begin
      if (clear_req) begin
         #1 clear_strobe = 1'h1;
         clear_mask = status_flags;
         @(posedge clock);
         #1 clear_strobe = 1'h0;
         clear_mask = '0;
      end
   end
endmodule : ecws_host_model
`default_nettype wire

// ==== verification/tb.sv ====
`default_nettype none
module tb;
   import ecws_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int DLY = 8;
   logic clock = 1'h0, sys_rst = 1'h1, wake_pin = 1'h0, in_sleep = 1'h0, rst_out = 1'h0;
   logic mode_write = 1'h0, wd_win = 1'h0, wd_to = 1'h1, lock = 1'h0, clear_req = 1'h0;
   logic trx_off = 1'h1;
   logic [11:0] ev = 12'h000, en = 12'h000;
   logic [3:0] x = 4'h0, seen = 4'h0, global_status;
   logic clear_strobe, rxd_low, sys_reset_req, to_reset_req, sleep_grant, wake_request;
   logic delay_running;
   ecws_flags_type clear_mask, status_flags;
   int err_count = 0, cmp_count = 0, n;
   always #10 clock = ~clock;
   always @(posedge clock) seen <= seen | {sys_reset_req, to_reset_req, sleep_grant, wake_request};
   ecws_event_capture #(.EVENT_DELAY_CYCLES(DLY)) ecws_event_capture_inst (.clock, .sys_rst,
      .power_on_evt(ev[11]), .overtemp_evt(ev[10]), .spi_bitcount_err(ev[9]),
      .illegal_code_err(x[1]), .locked_write_err(x[0]), .wd_overflow(ev[8]),
      .wd_early_trigger(x[2]), .wd_mode_window(wd_win), .wd_mode_timeout(wd_to),
      .sensor_over_evt(ev[7]), .sensor_under_evt(ev[6]), .mcu_supply_low_evt(ev[5]),
      .reset_threshold_sel(1'h1), .bus_silence_evt(ev[4]), .can_uv_deact_evt(ev[3]),
      .txd_clamp_evt(x[3]), .bus_wake_evt(ev[2]), .wake_pin, .overtemp_en(en[10]),
      .serial_fault_en(en[9]), .sensor_over_en(en[7]), .sensor_under_en(en[6]),
      .mcu_supply_low_en(en[5]), .bus_silence_enable(en[4]), .can_failure_en(en[3]),
      .bus_wake_en(en[2]), .wake_rise_en(en[1]), .wake_fall_en(en[0]), .in_sleep,
      .trx_offline(trx_off), .mcu_supply_on(~in_sleep), .system_reset_out(rst_out),
      .mode_write, .sbc_mode_field(3'h1), .sleep_lock_bit(lock), .clear_strobe, .clear_mask,
      .status_flags, .global_status, .rxd_low, .sys_reset_req, .to_reset_req, .sleep_grant,
      .wake_request, .delay_running);
   ecws_host_model ecws_host_model_inst (.clock, .clear_req, .status_flags, .clear_strobe,
      .clear_mask);
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic step(input int k);
      repeat (k) @(posedge clock);
      #1;
   endtask : step
   task automatic fire(input logic [11:0] v, input logic [3:0] w);
      ev = v;
      x = w;
      step(1);
      ev = 12'h000;
      x = 4'h0;
      step(1);
   endtask : fire
   task automatic clr;
      clear_req = 1'h1;
      step(1);
      clear_req = 1'h0;
      step(2);
   endtask : clr
   // Clear, then let the delay timer lapse
   task automatic rest;
      clr;
      step(DLY + 2);
   endtask : rest
   task automatic mode;
      seen = 4'h0;
      mode_write = 1'h1;
      step(1);
      mode_write = 1'h0;
      step(2);
   endtask : mode
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : close_out
   initial begin
      #(20 * 3000);
      err_count++;
      close_out;
   end
   initial begin
      step(8);
      sys_rst = 1'h0;
      chk(16'(status_flags), 16'h0000);
      fire(12'hFFC, 4'hB);
      chk(16'(status_flags), 16'h0900);
      rest;
      $display("test always captured done");
      en = 12'hFFF;
      for (int i = 2; i < 12; i++) begin
         fire(12'(1 << i), 4'h0);
         chk(16'(status_flags), 16'(1 << i));
         chk(16'(global_status), 16'(i > 7 ? 1 : i > 4 ? 2 : 4));
         chk(16'(rxd_low), 16'h0001);
         rest;
      end
      wake_pin = 1'h1;
      step(2);
      chk(16'(status_flags), 16'h0002);
      chk(16'(global_status), 16'h0008);
      rest;
      wake_pin = 1'h0;
      step(2);
      chk(16'(status_flags), 16'h0001);
      rest;
      trx_off = 1'h0;
      fire(12'h004, 4'h0);
      chk(16'(rxd_low), 16'h0000);
      trx_off = 1'h1;
      step(2);
      chk(16'(rxd_low), 16'h0001);
      rest;
      fire(12'h000, 4'hB);
      chk(16'(status_flags), 16'h0208);
      rest;
      $display("test enabled capture done");
      in_sleep = 1'h1;
      fire(12'h620, 4'hB);
      chk(16'(status_flags), 16'h0000);
      seen = 4'h0;
      fire(12'h004, 4'h0);
      chk(16'(status_flags), 16'h0004);
      chk(16'(seen[0]), 16'h0001);
      chk(16'(rxd_low), 16'h0001);
      in_sleep = 1'h0;
      rest;
      $display("test sleep capture done");
      seen = 4'h0;
      fire(12'h100, 4'h0);
      chk(16'(seen[3]), 16'h0000);
      fire(12'h100, 4'h0);
      chk(16'(seen[3]), 16'h0001);
      rest;
      wd_to = 1'h0;
      wd_win = 1'h1;
      seen = 4'h0;
      fire(12'h000, 4'h4);
      chk(16'(seen[3]), 16'h0001);
      chk(16'(status_flags), 16'h0100);
      rest;
      $display("test watchdog done");
      fire(12'h004, 4'h0);
      clr;
      chk(16'(rxd_low), 16'h0000);
      chk(16'(delay_running), 16'h0001);
      fire(12'h010, 4'h0);
      chk(16'(status_flags), 16'h0010);
      chk(16'(rxd_low), 16'h0000);
      n = 0;
      while (delay_running === 1'h1 && n < 20) begin
         step(1);
         n++;
      end
      chk(16'(n), 16'(DLY - 3));
      chk(16'(rxd_low), 16'h0001);
      rest;
      chk(16'(rxd_low), 16'h0000);
      rst_out = 1'h1;
      fire(12'h004, 4'h0);
      clr;
      chk(16'(delay_running), 16'h0001);
      rst_out = 1'h0;
      step(2);
      chk(16'(delay_running), 16'h0000);
      ev = 12'h400;
      step(1);
      clr;
      chk(16'(status_flags[10]), 16'h0001);
      ev = 12'h000;
      rest;
      $display("test delay timer done");
      fire(12'h004, 4'h0);
      mode;
      chk(16'(seen[2]), 16'h0001);
      rest;
      en = 12'hFF8;
      mode;
      chk(16'(seen[3]), 16'h0001);
      en = 12'hFFF;
      mode;
      chk(16'(seen), 16'h0002);
      lock = 1'h1;
      mode;
      chk(16'(status_flags), 16'h0200);
      chk(16'(seen), 16'h0000);
      $display("test sleep guard done");
      close_out;
   end
endmodule : tb
`default_nettype wire
